// ===== meas_ctrl_cfg.svh
`ifndef MEAS_CTRL_CFG_SVH
`define MEAS_CTRL_CFG_SVH
// Register addresses on the internal register port.
`define ADDR_MEAS_CONFIG      8'h1C
`define ADDR_CONT_CONFIG      8'h1D
`define REG_RESET_VALUE       8'h00
// Clock rate in kHz and the documented times.
`define CLK_KHZ               100000
`define MEAS_US_00            6600
`define MEAS_US_01            3500
`define MEAS_US_10            2000
`define MEAS_US_11            1200
`define RESTART_MS            20
// Periodic set intervals in samples.
`define PRD_0                 16'h0001
`define PRD_1                 16'h0019
`define PRD_2                 16'h004B
`define PRD_3                 16'h0064
`define PRD_4                 16'h00FA
`define PRD_5                 16'h01F4
`define PRD_6                 16'h03E8
`define PRD_7                 16'h07D0
`endif

// ===== meas_ctrl_pkg.sv
package meas_ctrl_pkg;
   // Measurement configuration register layout, msb first.
   typedef struct packed {
      logic       soft_restart;
      logic       selftest_negative;
      logic       selftest_positive;
      logic [2:0] axis_skip;          // Bit 2 is Z, bit 0 is X.
      logic       meas_length_sel_hi;
      logic       meas_length_sel_lo;
   } meas_cfg_t;
   // Continuous configuration register layout, msb first.
   typedef struct packed {
      logic       high_rate_boost;
      logic       factory_int_a;
      logic       factory_int_b;
      logic       continuous_run;
      logic       periodic_magnetize_en;
      logic [2:0] magnetize_interval;
   } cont_cfg_t;
   // Measurement sequencer states.
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_AXIS  = 2'b01,
      ST_DONE  = 2'b10
   } seq_state_t;
endpackage : meas_ctrl_pkg

// ===== axis_timer.sv
`timescale 1ns/1ps
`include "meas_ctrl_cfg.svh"
// Converts the length selector into a per-axis slot length in cycles.
module axis_timer #(
   parameter int CLK_KHZ = `CLK_KHZ
) (
   input  wire logic [1:0]  i_sel,      // Measurement length selector.
   output logic      [23:0] o_slot      // Cycles per axis slot.
);
   // Each axis takes one third of the full time, rounded down.
   // Multiply before dividing so clock figures below 1 MHz keep their slots.
   localparam int SLOT_00 = ((`MEAS_US_00 * CLK_KHZ) / 1000) / 3;
   localparam int SLOT_01 = ((`MEAS_US_01 * CLK_KHZ) / 1000) / 3;
   localparam int SLOT_10 = ((`MEAS_US_10 * CLK_KHZ) / 1000) / 3;
   localparam int SLOT_11 = ((`MEAS_US_11 * CLK_KHZ) / 1000) / 3;

   // ==========================================================
   // Slot selection
   // ==========================================================
   // Plain mux on the selector.
   always_comb begin
      case (i_sel)
         2'b00:   o_slot = 24'(SLOT_00);
         2'b01:   o_slot = 24'(SLOT_01);
         2'b10:   o_slot = 24'(SLOT_10);
         default: o_slot = 24'(SLOT_11);
      endcase
   end
endmodule : axis_timer

// ===== magnetometer_measure_control.sv
`timescale 1ns/1ps
`include "meas_ctrl_cfg.svh"
module magnetometer_measure_control #(
   parameter int          CLK_KHZ    = `CLK_KHZ,
   parameter int unsigned RESTART_CY = `RESTART_MS * CLK_KHZ
) (
   input  wire logic        i_clock,        // System clock, 100 MHz.
   input  wire logic        i_rst_n,        // Asynchronous reset, low active.
   input  wire logic        i_reg_wr,       // Register write strobe.
   input  wire logic        i_reg_rd,       // Register read strobe.
   input  wire logic [7:0]  i_reg_addr,     // Register address.
   input  wire logic [7:0]  i_reg_wdata,    // Register write data.
   output logic      [7:0]  o_reg_rdata,    // Register read data.
   output logic             o_reg_ack,      // Access accepted this cycle.
   input  wire logic        i_auto_magnetize_en, // Automatic set/reset enable.
   input  wire logic        i_period_calc,  // Period calculation start pulse.
   input  wire logic [31:0] i_period_cycles,// Period from output rate, 0 if none.
   input  wire logic        i_meas_trigger, // On-demand measurement pulse.
   output logic             o_period_load,  // Request to latch the period.
   output logic             o_continuous,   // Continuous mode active.
   output logic             o_period_tick,  // Period counter wrapped.
   output logic [2:0]       o_axis_active,  // One-hot axis being measured.
   output logic [2:0]       o_axis_update,  // Write strobe for axis result.
   output logic             o_meas_done,    // Measurement sequence finished.
   output logic             o_set_pulse,    // Magnetizing set request.
   output logic             o_reset_pulse,  // Magnetizing reset request.
   output logic             o_selftest_pos, // Self-test coil, positive.
   output logic             o_selftest_neg, // Self-test coil, negative.
   output logic             o_high_rate,    // High-rate boost.
   output logic             o_otp_reload,   // Trim reload during startup.
   output logic             o_busy          // Startup in progress.
);
   // ==========================================================
   // Reset release
   // ==========================================================
   logic rst_s1_q;   // First release stage.
   logic rst_n_q;    // Released reset used everywhere.
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_s1_q <= 1'b0;
         rst_n_q  <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n_q  <= rst_s1_q;
      end
   end

   // ==========================================================
   // State declarations
   // ==========================================================
   meas_ctrl_pkg::meas_cfg_t  mcfg_q, mcfg_d;   // Measurement config.
   meas_ctrl_pkg::cont_cfg_t  ccfg_q, ccfg_d;   // Continuous config.
   meas_ctrl_pkg::seq_state_t st_q, st_d;       // Sequencer state.
   logic        period_ok_q, period_ok_d;       // Period was computed.
   logic [31:0] period_q, period_d;             // Latched period.
   logic [31:0] pcnt_q, pcnt_d;                 // Period counter.
   logic [31:0] rcnt_q, rcnt_d;                 // Restart timer.
   logic [1:0]  axis_q, axis_d;                 // Axis index.
   logic [23:0] tcnt_q, tcnt_d;                 // Slot timer.
   logic [15:0] scnt_q, scnt_d;                 // Sample count since set.
   logic [7:0]  rdata_q, rdata_d;               // Read data register.
   logic        set_q, set_d;                   // Set pulse register.
   logic        rst_p_q, rst_p_d;               // Reset pulse register.
   logic        done_q, done_d;                 // Done pulse register.
   logic [2:0]  upd_q, upd_d;                   // Axis update register.
   logic [23:0] slot;                           // Slot length.
   logic        busy;                           // Startup running.
   logic        wr_m, wr_c;                     // Decoded writes.
   logic        prd_active;                     // Periodic set in force.

   axis_timer #(.CLK_KHZ(CLK_KHZ)) u_timer (
      .i_sel  ({mcfg_q.meas_length_sel_hi, mcfg_q.meas_length_sel_lo}),
      .o_slot (slot)
   );

   // Interval code to samples per set pulse.
   function automatic logic [15:0] interval(input logic [2:0] code);
      case (code)
         3'h0:    interval = `PRD_0;
         3'h1:    interval = `PRD_1;
         3'h2:    interval = `PRD_2;
         3'h3:    interval = `PRD_3;
         3'h4:    interval = `PRD_4;
         3'h5:    interval = `PRD_5;
         3'h6:    interval = `PRD_6;
         default: interval = `PRD_7;
      endcase
   endfunction : interval

   // Next axis not skipped at or after the given index, 3 if none.
   function automatic logic [1:0] next_axis(input logic [1:0] from, input logic [2:0] skip);
      logic [1:0] r;
      r = 2'd3;
      for (int i = 2; i >= 0; i--) begin
         if (!skip[i] && (2'(i) >= from)) begin
            r = 2'(i);
         end
      end
      next_axis = r;
   endfunction : next_axis

   assign busy       = (rcnt_q != 32'h0);
   // Register decode is blocked during startup so the host sees no answer.
   assign wr_m       = i_reg_wr && !busy && (i_reg_addr == `ADDR_MEAS_CONFIG);
   assign wr_c       = i_reg_wr && !busy && (i_reg_addr == `ADDR_CONT_CONFIG);
   assign prd_active = ccfg_q.periodic_magnetize_en && i_auto_magnetize_en
                       && o_continuous;

   // ==========================================================
   // Next-state logic
   // ==========================================================
   // All control state computed in one place; soft restart overrides all but the read data.
   always_comb begin
      mcfg_d      = mcfg_q;
      ccfg_d      = ccfg_q;
      st_d        = st_q;
      period_ok_d = period_ok_q;
      period_d    = period_q;
      pcnt_d      = pcnt_q;
      rcnt_d      = busy ? rcnt_q - 32'h1 : rcnt_q;
      axis_d      = axis_q;
      tcnt_d      = tcnt_q;
      scnt_d      = scnt_q;
      rdata_d     = rdata_q;
      set_d       = 1'b0;
      rst_p_d     = 1'b0;
      done_d      = 1'b0;
      upd_d       = 3'h0;
      if (wr_m) begin
         mcfg_d = meas_ctrl_pkg::meas_cfg_t'(i_reg_wdata);
      end
      if (wr_c) begin
         // Continuous run only sticks once a nonzero period exists.
         ccfg_d = meas_ctrl_pkg::cont_cfg_t'(i_reg_wdata);
         ccfg_d.continuous_run = ccfg_d.continuous_run && period_ok_q
                                 && (period_q != 32'h0);
         if (ccfg_d.continuous_run && !ccfg_q.continuous_run) begin
            pcnt_d = 32'h0;
         end
      end
      if (i_period_calc && !busy) begin
         period_d    = i_period_cycles;
         period_ok_d = 1'b1;
      end
      if (ccfg_q.continuous_run) begin
         pcnt_d = (pcnt_q + 32'h1 >= period_q) ? 32'h0 : pcnt_q + 32'h1;
      end
      if (i_reg_rd && !busy) begin
         if (i_reg_addr == `ADDR_MEAS_CONFIG) begin
            rdata_d = mcfg_q;
         end else if (i_reg_addr == `ADDR_CONT_CONFIG) begin
            rdata_d = ccfg_q;
         end else begin
            rdata_d = 8'h00;
         end
      end
      case (st_q)
         meas_ctrl_pkg::ST_IDLE: begin
            if (!busy && (i_meas_trigger || o_period_tick)) begin
               axis_d = next_axis(2'd0, mcfg_q.axis_skip);
               tcnt_d = 24'h0;
               // Magnetizing pulses in the first cycle of the sequence.
               if (prd_active) begin
                  set_d = (scnt_q == 16'h0);
               end else if (i_auto_magnetize_en) begin
                  set_d   = 1'b1;
                  rst_p_d = 1'b1;
               end
               st_d = (next_axis(2'd0, mcfg_q.axis_skip) == 2'd3) ?
                      meas_ctrl_pkg::ST_DONE : meas_ctrl_pkg::ST_AXIS;
            end
         end
         meas_ctrl_pkg::ST_AXIS: begin
            if (tcnt_q + 24'h1 >= slot) begin
               tcnt_d = 24'h0;
               // Only the measured axis result is written; others keep theirs.
               upd_d[axis_q] = 1'b1;
               axis_d = (axis_q == 2'd2) ? 2'd3 :
                        next_axis(axis_q + 2'd1, mcfg_q.axis_skip);
               if (axis_d == 2'd3) begin
                  st_d = meas_ctrl_pkg::ST_DONE;
               end
            end else begin
               tcnt_d = tcnt_q + 24'h1;
            end
         end
         default: begin
            done_d = 1'b1;
            if (prd_active) begin
               scnt_d = (scnt_q + 16'h1 >= interval(ccfg_q.magnetize_interval)) ?
                        16'h0 : scnt_q + 16'h1;
            end
            st_d = meas_ctrl_pkg::ST_IDLE;
         end
      endcase
      // The sample counter restart comes after the sequencer, so a sequence
      // ending in the same cycle cannot advance the counter past the restart.
      if (!ccfg_d.continuous_run
          || (wr_c && (ccfg_d.magnetize_interval != ccfg_q.magnetize_interval))) begin
         scnt_d = 16'h0;
      end
      if (wr_m && i_reg_wdata[7]) begin
         // Restart: clear every register except the read data and run the startup timer.
         mcfg_d      = `REG_RESET_VALUE;
         ccfg_d      = `REG_RESET_VALUE;
         st_d        = meas_ctrl_pkg::ST_IDLE;
         period_ok_d = 1'b0;
         period_d    = 32'h0;
         pcnt_d      = 32'h0;
         scnt_d      = 16'h0;
         rcnt_d      = RESTART_CY;
         // Drop pulses launched in this cycle so nothing runs during startup.
         set_d       = 1'b0;
         rst_p_d     = 1'b0;
         done_d      = 1'b0;
         upd_d       = 3'h0;
         axis_d      = 2'd0;
         tcnt_d      = 24'h0;
      end
   end

   // ==========================================================
   // Registers
   // ==========================================================
   always_ff @(posedge i_clock or negedge rst_n_q) begin
      if (!rst_n_q) begin
         mcfg_q      <= `REG_RESET_VALUE;
         ccfg_q      <= `REG_RESET_VALUE;
         st_q        <= meas_ctrl_pkg::ST_IDLE;
         period_ok_q <= 1'b0;
         period_q    <= 32'h0;
         pcnt_q      <= 32'h0;
         rcnt_q      <= 32'h0;
         axis_q      <= 2'd0;
         tcnt_q      <= 24'h0;
         scnt_q      <= 16'h0;
         rdata_q     <= 8'h00;
         set_q       <= 1'b0;
         rst_p_q     <= 1'b0;
         done_q      <= 1'b0;
         upd_q       <= 3'h0;
      end else begin
         mcfg_q      <= mcfg_d;
         ccfg_q      <= ccfg_d;
         st_q        <= st_d;
         period_ok_q <= period_ok_d;
         period_q    <= period_d;
         pcnt_q      <= pcnt_d;
         rcnt_q      <= rcnt_d;
         axis_q      <= axis_d;
         tcnt_q      <= tcnt_d;
         scnt_q      <= scnt_d;
         rdata_q     <= rdata_d;
         set_q       <= set_d;
         rst_p_q     <= rst_p_d;
         done_q      <= done_d;
         upd_q       <= upd_d;
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   assign o_reg_rdata    = rdata_q;
   assign o_reg_ack      = (i_reg_wr || i_reg_rd) && !busy;
   assign o_period_load  = i_period_calc && !busy;
   assign o_continuous   = ccfg_q.continuous_run;
   assign o_period_tick  = ccfg_q.continuous_run && (pcnt_q + 32'h1 >= period_q);
   assign o_axis_active  = (st_q == meas_ctrl_pkg::ST_AXIS) ? (3'h1 << axis_q) : 3'h0;
   assign o_axis_update  = upd_q;
   assign o_meas_done    = done_q;
   assign o_set_pulse    = set_q;
   assign o_reset_pulse  = rst_p_q;
   assign o_selftest_pos = mcfg_q.selftest_positive;
   assign o_selftest_neg = mcfg_q.selftest_negative;
   assign o_high_rate    = ccfg_q.high_rate_boost;
   assign o_otp_reload   = busy;
   assign o_busy         = busy;
endmodule : magnetometer_measure_control

// ===== meas_ctrl_assertions.sv
`timescale 1ns/1ps
// =====================================================================
// Port checker for the measurement control block.
module meas_ctrl_assertions (
   input wire logic       i_clock,             // Clock.
   input wire logic       i_rst_n,             // Reset, low active.
   input wire logic       i_reg_wr,            // Write strobe.
   input wire logic       i_reg_rd,            // Read strobe.
   input wire logic [7:0] i_reg_addr,          // Address.
   input wire logic [7:0] i_reg_wdata,         // Write data.
   input wire logic       i_auto_magnetize_en, // Auto set/reset.
   input wire logic       o_reg_ack,           // Acknowledge.
   input wire logic       o_continuous,        // Continuous mode.
   input wire logic [2:0] o_axis_active,       // Axis in progress.
   input wire logic [2:0] o_axis_update,       // Axis result strobe.
   input wire logic       o_set_pulse,         // Set request.
   input wire logic       o_reset_pulse,       // Reset request.
   input wire logic       o_selftest_pos,      // Coil, positive.
   input wire logic       o_selftest_neg,      // Coil, negative.
   input wire logic       o_high_rate,         // Boost.
   input wire logic       o_otp_reload,        // Trim reload.
   input wire logic       o_busy               // Startup running.
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);
   // Any strobe, accepted or not.
   logic req;
   assign req = i_reg_wr | i_reg_rd;
   // An accepted write to one address.
   sequence s_wr(a);
      i_reg_wr && o_reg_ack && i_reg_addr == a;
   endsequence
   // An accepted write that asks for a restart.
   sequence s_restart;
      s_wr(8'h1C) ##0 i_reg_wdata[7];
   endsequence
   a_busy_refuse: assert property (req && o_busy |-> !o_reg_ack)
      else $error("access acknowledged during startup");
   a_busy_quiet: assert property (o_busy |-> o_axis_active == 3'h0 && !o_set_pulse)
      else $error("measurement activity during startup");
   a_restart_busy: assert property (s_restart |=> o_busy && o_otp_reload)
      else $error("restart did not start the startup interval");
   a_restart_clear: assert property (s_restart |=> !o_continuous && !o_high_rate)
      else $error("restart left configuration set");
   a_selftest_pos: assert property (s_wr(8'h1C) ##0 !i_reg_wdata[7]
      |=> o_selftest_pos == $past(i_reg_wdata[5]))
      else $error("positive coil drive differs from register");
   a_selftest_neg: assert property (s_wr(8'h1C) ##0 !i_reg_wdata[7]
      |=> o_selftest_neg == $past(i_reg_wdata[6]))
      else $error("negative coil drive differs from register");
   a_axis_single: assert property ($onehot0(o_axis_active))
      else $error("more than one axis active");
   a_update_active: assert property (|o_axis_update
      |-> ($past(o_axis_active) & o_axis_update) == o_axis_update)
      else $error("result strobe for an axis that was not measured");
   a_cont_cause: assert property ($rose(o_continuous)
      |-> $past(i_reg_wr && i_reg_addr == 8'h1D && i_reg_wdata[4]))
      else $error("continuous mode entered without a write");
   a_pulse_auto: assert property (o_set_pulse || o_reset_pulse
      |-> $past(i_auto_magnetize_en))
      else $error("magnetizing pulse while automatic mode is off");
   a_high_rate: assert property (s_wr(8'h1D) |=> o_high_rate == $past(i_reg_wdata[7]))
      else $error("boost output differs from register");
endmodule : meas_ctrl_assertions

// ===== host_model.sv
`timescale 1ns/1ps
// =====================================================================
// Host side: register strobes, period start and measurement trigger.
module host_model (
   input  wire logic        i_clock,         // Clock.
   input  wire logic        i_reg_ack,       // Access accepted.
   input  wire logic [7:0]  i_reg_rdata,     // Read data.
   input  wire logic        i_period_load,   // Period latch echo.
   output logic             o_reg_wr,        // Write strobe.
   output logic             o_reg_rd,        // Read strobe.
   output logic      [7:0]  o_reg_addr,      // Address.
   output logic      [7:0]  o_reg_wdata,     // Write data.
   output logic             o_period_calc,   // Period start pulse.
   output logic      [31:0] o_period_cycles, // Period in cycles.
   output logic             o_meas_trigger   // Measurement pulse.
);
   // Quiet bus at time zero.
   initial begin
      {o_reg_wr, o_reg_rd, o_period_calc, o_meas_trigger} = 4'h0;
      {o_reg_addr, o_reg_wdata, o_period_cycles} = 48'h0;
   end
   // One-cycle access; released lines show the inverse so stale data never passes.
   task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
                         output logic ack, output logic [7:0] q);
      @(posedge i_clock);
      o_reg_wr <= w;
      o_reg_rd <= !w;
      o_reg_addr <= a;
      o_reg_wdata <= d;
      #1 ack = i_reg_ack;
      @(posedge i_clock);
      {o_reg_wr, o_reg_rd} <= 2'h0;
      o_reg_addr <= ~a;
      o_reg_wdata <= ~d;
      #1 q = i_reg_rdata;
   endtask : access
   // Period start, given before continuous mode is asked for.
   task automatic pcalc(input logic [31:0] c, output logic ld);
      @(posedge i_clock);
      o_period_calc <= 1'b1;
      o_period_cycles <= c;
      #1 ld = i_period_load;
      @(posedge i_clock);
      o_period_calc <= 1'b0;
      #1;
   endtask : pcalc
   // On-demand measurement request.
   task automatic trig();
      @(posedge i_clock);
      o_meas_trigger <= 1'b1;
      @(posedge i_clock);
      o_meas_trigger <= 1'b0;
      #1;
   endtask : trig
endmodule : host_model

// ===== tb_magnetometer_measure_control.sv
`timescale 1ns/1ps
// =====================================================================
// Self-checking bench for the measurement control block.
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin bad_count++; \
   $display("ERROR %0t got %0h expected %0h", $time, (a), (e)); end end
module tb_magnetometer_measure_control;
   logic        i_clock = 1'b0, i_rst_n = 1'b0, i_auto_magnetize_en = 1'b1;
   logic        i_reg_wr, i_reg_rd, i_period_calc, i_meas_trigger, ack;
   logic [7:0]  i_reg_addr, i_reg_wdata, o_reg_rdata, q;
   logic [31:0] i_period_cycles;
   logic        o_reg_ack, o_period_load, o_continuous, o_period_tick, o_meas_done;
   logic [2:0]  o_axis_active, o_axis_update;
   logic        o_set_pulse, o_reset_pulse, o_selftest_pos, o_selftest_neg;
   logic        o_high_rate, o_otp_reload, o_busy;
   int          bad_count = 0, check_count = 0, set_n, rst_n, tick_n, done_n;
   int          cyc = 0, last_tick = 0, gap = 0, act_n[3], upd_n[3];
   always #5 i_clock = ~i_clock;
   // Small clock figure keeps slots at 66/35/20/12 cycles.
   magnetometer_measure_control #(.CLK_KHZ(30), .RESTART_CY(50)) magnetometer_measure_control_i (
      .i_clock, .i_rst_n, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata,
      .o_reg_ack, .i_auto_magnetize_en, .i_period_calc, .i_period_cycles, .i_meas_trigger,
      .o_period_load, .o_continuous, .o_period_tick, .o_axis_active, .o_axis_update,
      .o_meas_done, .o_set_pulse, .o_reset_pulse, .o_selftest_pos, .o_selftest_neg,
      .o_high_rate, .o_otp_reload, .o_busy);
   host_model host_model_i (.i_clock, .i_reg_ack(o_reg_ack), .i_reg_rdata(o_reg_rdata),
      .i_period_load(o_period_load), .o_reg_wr(i_reg_wr), .o_reg_rd(i_reg_rd),
      .o_reg_addr(i_reg_addr), .o_reg_wdata(i_reg_wdata), .o_period_calc(i_period_calc),
      .o_period_cycles(i_period_cycles), .o_meas_trigger(i_meas_trigger));
   // Event counters; sampling at the edge sees the settled previous cycle.
   always @(posedge i_clock) begin
      cyc++;
      for (int k = 0; k < 3; k++) begin
         act_n[k] += int'(o_axis_active[k] === 1'b1);
         upd_n[k] += int'(o_axis_update[k] === 1'b1);
      end
      set_n += int'(o_set_pulse === 1'b1);
      rst_n += int'(o_reset_pulse === 1'b1);
      done_n += int'(o_meas_done === 1'b1);
      if (o_period_tick === 1'b1) begin
         tick_n++;
         gap = cyc - last_tick;
         last_tick = cyc;
      end
   end
   task automatic clr();
      {set_n, rst_n, tick_n, done_n} = '0;
      act_n = '{0, 0, 0};
      upd_n = '{0, 0, 0};
   endtask : clr
   // Bounded wait for a number of period ticks, then let pulses land.
   task automatic wait_ticks(input int n);
      for (int k = 0; k < 3000 && tick_n < n; k++) @(posedge i_clock);
      repeat (3) @(posedge i_clock);
      #1;
      `CHK(tick_n >= n, 1'b1)
   endtask : wait_ticks
   task automatic t_regs();
      host_model_i.access(1'b0, 8'h1C, 8'h00, ack, q); `CHK(q, 8'h00)
      host_model_i.access(1'b0, 8'h1D, 8'h00, ack, q); `CHK(q, 8'h00)
      host_model_i.access(1'b0, 8'h1E, 8'h00, ack, q); `CHK(q, 8'h00)
      host_model_i.access(1'b1, 8'h1C, 8'h20, ack, q); `CHK({o_selftest_pos, o_selftest_neg}, 2'h2)
      host_model_i.access(1'b1, 8'h1C, 8'h40, ack, q); `CHK({o_selftest_pos, o_selftest_neg}, 2'h1)
      host_model_i.access(1'b0, 8'h1C, 8'h00, ack, q); `CHK(q, 8'h40)
      host_model_i.access(1'b1, 8'h1D, 8'h80, ack, q); `CHK(o_high_rate, 1'b1)
      host_model_i.access(1'b1, 8'h1D, 8'h90, ack, q);
      host_model_i.access(1'b0, 8'h1D, 8'h00, ack, q); `CHK(q, 8'h80)
      host_model_i.pcalc(32'h0, ack); `CHK(ack, 1'b1)
      host_model_i.access(1'b1, 8'h1D, 8'h10, ack, q); `CHK(o_continuous, 1'b0)
   endtask : t_regs
   task automatic t_measure(input logic [1:0] bw, input logic [2:0] skip);
      int slot;
      slot = (bw == 2'h0) ? 66 : (bw == 2'h1) ? 35 : (bw == 2'h2) ? 20 : 12;
      host_model_i.access(1'b1, 8'h1C, {3'h0, skip, bw}, ack, q);
      clr();
      host_model_i.trig();
      for (int k = 0; k < 1000 && done_n == 0; k++) @(posedge i_clock);
      repeat (2) @(posedge i_clock);
      #1;
      for (int k = 0; k < 3; k++) begin
         `CHK(act_n[k], skip[k] ? 0 : slot)
         `CHK(upd_n[k], skip[k] ? 0 : 1)
      end
      `CHK(done_n, 1)
      `CHK(set_n, 1)
      `CHK(rst_n, 1)
   endtask : t_measure
   task automatic t_restart();
      host_model_i.access(1'b1, 8'h1D, 8'h80, ack, q);
      host_model_i.access(1'b1, 8'h1C, 8'h80, ack, q); `CHK({o_busy, o_otp_reload}, 2'h3)
      host_model_i.access(1'b1, 8'h1D, 8'h80, ack, q); `CHK(ack, 1'b0)
      // Host waits out the whole startup before the next access.
      for (int k = 0; k < 200 && o_busy !== 1'b0; k++) @(posedge i_clock) #1;
      host_model_i.access(1'b0, 8'h1D, 8'h00, ack, q); `CHK({ack, q}, 9'h100)
   endtask : t_restart
   task automatic t_periodic();
      host_model_i.access(1'b1, 8'h1C, 8'h03, ack, q);
      host_model_i.pcalc(32'd50, ack);
      clr();
      host_model_i.access(1'b1, 8'h1D, 8'h19, ack, q); `CHK(o_continuous, 1'b1)
      wait_ticks(26);
      `CHK(set_n, 2)
      `CHK(rst_n, 0)
      `CHK(gap, 50)
      host_model_i.access(1'b1, 8'h1D, 8'h18, ack, q);
      clr();
      wait_ticks(1);
      clr();
      wait_ticks(4); `CHK(set_n, 4)
      @(posedge i_clock) i_auto_magnetize_en <= 1'b0;
      clr();
      wait_ticks(1);
      clr();
      wait_ticks(3); `CHK(set_n, 0)
      `CHK(rst_n, 0)
      host_model_i.access(1'b1, 8'h1D, 8'h00, ack, q); `CHK(o_continuous, 1'b0)
      clr();
      repeat (100) @(posedge i_clock);
      #1; `CHK(tick_n, 0)
   endtask : t_periodic
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : results
   // Main sequence: reset, then every scenario in turn.
   initial begin
      clr();
      repeat (10) @(posedge i_clock);
      i_rst_n <= 1'b1;
      repeat (3) @(posedge i_clock);
      t_regs();
      for (int b = 0; b < 4; b++) t_measure(2'(b), 3'h0);
      t_measure(2'h3, 3'h1);
      t_measure(2'h3, 3'h6);
      t_restart();
      t_periodic();
      results();
   end
   // Watchdog: the scenarios need well under 10000 cycles.
   initial begin
      #200000;
      bad_count++;
      results();
   end
endmodule : tb_magnetometer_measure_control
bind magnetometer_measure_control meas_ctrl_assertions meas_ctrl_assertions_i (
   .i_clock, .i_rst_n, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata,
   .i_auto_magnetize_en, .o_reg_ack, .o_continuous, .o_axis_active, .o_axis_update,
   .o_set_pulse, .o_reset_pulse, .o_selftest_pos, .o_selftest_neg, .o_high_rate,
   .o_otp_reload, .o_busy);
